// [hw/pgp_pkg.sv]
// constants, field layout and carrier types of the three-generator pwm group
// assumes an apb slave with 32-bit data, one register per aligned word
package pgp_pkg;

    // register indices; byte address is four times the index
    localparam logic [5:0] IDX_SRC_GATE = 6'h33;
    localparam logic [5:0] IDX_GEN0_CTL = 6'h34;
    localparam logic [5:0] IDX_GEN1_CTL = 6'h35;
    localparam logic [5:0] IDX_GEN2_CTL = 6'h36;
    localparam logic [5:0] IDX_CLK_CFG  = 6'h37;
    localparam logic [5:0] IDX_UB_HIGH  = 6'h38;
    localparam logic [5:0] IDX_UB_LOW   = 6'h39;
    localparam logic [5:0] IDX_DUTY_H0  = 6'h3A;
    localparam logic [5:0] IDX_DUTY_L0  = 6'h3B;

    // source and gating register fields
    localparam int SRC_DOUBLE_BIT = 3;
    localparam int GATE_LSB       = 0;

    // generator control fields
    localparam int CTL_STATUS_BIT = 6;
    localparam int CTL_INVERT_BIT = 5;
    localparam int CTL_SEL_BIT    = 4;
    localparam int CTL_PIN_BIT    = 3;
    localparam int CTL_ROUTE_LSB  = 2;
    localparam int CTL_MIX_BIT    = 0;

    // clock register fields
    localparam int CLK_EN_BIT     = 7;
    localparam int CLK_PRE_LSB    = 4;
    localparam int CLK_SRC_BIT    = 0;

    // bound and duty field positions
    localparam int UBL_LSB        = 6;
    localparam int DTL_LSB        = 5;

    // gen2 pin route codes
    localparam logic [1:0] ROUTE_NONE = 2'h0;
    localparam logic [1:0] ROUTE_BIT0 = 2'h1;
    localparam logic [1:0] ROUTE_BIT7 = 2'h2;

    // reset values
    localparam logic [7:0] RST_REG8   = 8'h00;
    localparam logic [2:0] RST_DTL    = 3'h0;
    localparam logic [10:0] RST_DUTY  = 11'h000;
    localparam logic [10:0] RST_CNT   = 11'h000;
    localparam logic [6:0] RST_PRE    = 7'h00;

    typedef struct packed {
        logic       invert;
        logic       sel;
        logic [1:0] route;
        logic       mix_or;
    } pgp_genctl_s;

    typedef struct packed {
        logic out;
        logic oe;
    } pgp_pin_s;

endpackage

// [hw/pgp_top.sv]
// three pwm generators on one shared 11-bit counter, apb register access
// assumes oscillator ticks and comparator result are synchronous to SYS_CLK
//
// Implementation choice: the APB interface to the registers.
`timescale 1ns/1ps
module pgp_top (
    // clock and reset
    input  wire logic        SYS_CLK,
    input  wire logic        NRST,
    // apb slave
    input  wire logic        PSEL,
    input  wire logic        PENABLE,
    input  wire logic        PWRITE,
    input  wire logic [7:0]  PADDR,
    input  wire logic [31:0] PWDATA,
    output logic      [31:0] PRDATA,
    output logic             PREADY,
    output logic             PSLVERR,
    // fast oscillator ticks, one-cycle pulses at 16 and 32 MHz
    input  wire logic        FAST_OSC_TICK,
    input  wire logic        FAST_OSC_X2_TICK,
    // comparator result
    input  wire logic        CMP_RESULT,
    // port a pins
    output logic             PORT_A_BIT0_OUT,
    output logic             PORT_A_BIT0_OE,
    output logic             PORT_A_BIT3_OUT,
    output logic             PORT_A_BIT3_OE,
    output logic             PORT_A_BIT4_OUT,
    output logic             PORT_A_BIT4_OE,
    output logic             PORT_A_BIT7_OUT,
    output logic             PORT_A_BIT7_OE
);

    logic [7:0]          src_gate_r;
    pgp_pkg::pgp_genctl_s ctl_r [3];
    logic [7:0]          clk_cfg_r;
    logic [7:0]          ub_high_r;
    logic [1:0]          ub_low_r;
    logic [2:0]          dtl_r [3];
    logic [7:0]          dth_r [3];
    logic [10:0]         duty_r [3];
    logic [10:0]         cnt_r;
    logic [6:0]          pre_r;
    logic [2:0]          gen_out_r;
    logic                half_r;
    logic                w2_prev_r;
    pgp_pkg::pgp_pin_s   pin0_r;
    pgp_pkg::pgp_pin_s   pin3_r;
    pgp_pkg::pgp_pin_s   pin4_r;
    pgp_pkg::pgp_pin_s   pin7_r;

    logic [5:0]  idx;
    logic        hit;
    logic        wr_en;
    logic        group_en;
    logic        src_tick;
    logic        pre_tick;
    logic [6:0]  pre_mask;
    logic [10:0] bound;
    logic [2:0]  raw;
    logic [2:0]  wave;
    logic [2:0]  sel_out;
    logic [31:0] rd_nxt;

    assign idx   = PADDR[7:2];
    assign hit   = (idx >= pgp_pkg::IDX_SRC_GATE) && (idx <= pgp_pkg::IDX_DUTY_L0 + 6'h4);
    assign wr_en = PSEL && PENABLE && PREADY && PWRITE && hit;

    // apb: answer in the second access cycle, errors on unmapped words
    always_ff @(posedge SYS_CLK or negedge NRST) begin
        if (!NRST) begin
            PREADY  <= 1'b0;
            PSLVERR <= 1'b0;
            PRDATA  <= 32'h0000_0000;
        end else begin
            PREADY  <= PSEL && PENABLE && !PREADY;
            PSLVERR <= PSEL && PENABLE && !PREADY && !hit;
            if (PSEL && PENABLE && !PREADY) begin
                PRDATA <= (PWRITE || !hit) ? 32'h0000_0000 : rd_nxt;
            end
        end
    end

    // read mux; write-only and reserved bits read as zero
    always_comb begin
        rd_nxt = 32'h0000_0000;
        case (idx)
            pgp_pkg::IDX_GEN0_CTL, pgp_pkg::IDX_GEN1_CTL, pgp_pkg::IDX_GEN2_CTL: begin
                for (int i = 0; i < 3; i++) begin
                    if (idx == pgp_pkg::IDX_GEN0_CTL + 6'(i)) begin
                        rd_nxt[pgp_pkg::CTL_STATUS_BIT] = gen_out_r[i];
                        rd_nxt[pgp_pkg::CTL_INVERT_BIT] = ctl_r[i].invert;
                        rd_nxt[pgp_pkg::CTL_SEL_BIT]    = ctl_r[i].sel;
                        if (i == 2) begin
                            rd_nxt[pgp_pkg::CTL_ROUTE_LSB +: 2] = ctl_r[i].route;
                        end else begin
                            rd_nxt[pgp_pkg::CTL_PIN_BIT] = ctl_r[i].route[1];
                        end
                        if (i == 0) begin
                            rd_nxt[pgp_pkg::CTL_MIX_BIT] = ctl_r[i].mix_or;
                        end
                    end
                end
            end
            pgp_pkg::IDX_CLK_CFG: rd_nxt[7:0] = clk_cfg_r;
            pgp_pkg::IDX_UB_HIGH: rd_nxt[7:0] = ub_high_r;
            pgp_pkg::IDX_UB_LOW:  rd_nxt[pgp_pkg::UBL_LSB +: 2] = ub_low_r;
            default: begin
                for (int i = 0; i < 3; i++) begin
                    if (idx == pgp_pkg::IDX_DUTY_H0 + 6'(2 * i)) begin
                        rd_nxt[7:0] = dth_r[i];
                    end
                    if (idx == pgp_pkg::IDX_DUTY_L0 + 6'(2 * i)) begin
                        rd_nxt[pgp_pkg::DTL_LSB +: 3] = dtl_r[i];
                    end
                end
            end
        endcase
    end

    // shared configuration registers
    always_ff @(posedge SYS_CLK or negedge NRST) begin
        if (!NRST) begin
            src_gate_r <= pgp_pkg::RST_REG8;
            clk_cfg_r  <= pgp_pkg::RST_REG8;
            ub_high_r  <= pgp_pkg::RST_REG8;
            ub_low_r   <= 2'h0;
        end else if (wr_en) begin
            case (idx)
                pgp_pkg::IDX_SRC_GATE: src_gate_r <= {4'h0, PWDATA[3:0]};
                pgp_pkg::IDX_CLK_CFG:  clk_cfg_r  <= {PWDATA[7:4], 3'h0, PWDATA[0]};
                pgp_pkg::IDX_UB_HIGH:  ub_high_r  <= PWDATA[7:0];
                pgp_pkg::IDX_UB_LOW:   ub_low_r   <= PWDATA[pgp_pkg::UBL_LSB +: 2];
                default: ;
            endcase
        end
    end

    // per-generator control and duty
    for (genvar g = 0; g < 3; g++) begin : gen_regs
        localparam logic [5:0] CTL_IDX = pgp_pkg::IDX_GEN0_CTL + 6'(g);
        localparam logic [5:0] DTH_IDX = pgp_pkg::IDX_DUTY_H0 + 6'(2 * g);
        localparam logic [5:0] DTL_IDX = pgp_pkg::IDX_DUTY_L0 + 6'(2 * g);

        always_ff @(posedge SYS_CLK or negedge NRST) begin
            if (!NRST) begin
                ctl_r[g] <= '0;
            end else if (wr_en && idx == CTL_IDX) begin
                ctl_r[g].invert <= PWDATA[pgp_pkg::CTL_INVERT_BIT];
                ctl_r[g].sel    <= PWDATA[pgp_pkg::CTL_SEL_BIT];
                if (g == 2) begin
                    ctl_r[g].route <= PWDATA[pgp_pkg::CTL_ROUTE_LSB +: 2];
                end else begin
                    ctl_r[g].route <= {PWDATA[pgp_pkg::CTL_PIN_BIT], 1'b0};
                end
                ctl_r[g].mix_or <= (g == 0) ? PWDATA[pgp_pkg::CTL_MIX_BIT] : 1'b0;
            end
        end

        // the high write commits both halves so the duty never shows a torn value
        always_ff @(posedge SYS_CLK or negedge NRST) begin
            if (!NRST) begin
                dtl_r[g]  <= pgp_pkg::RST_DTL;
                dth_r[g]  <= pgp_pkg::RST_REG8;
                duty_r[g] <= pgp_pkg::RST_DUTY;
            end else if (wr_en && idx == DTL_IDX) begin
                dtl_r[g] <= PWDATA[pgp_pkg::DTL_LSB +: 3];
            end else if (wr_en && idx == DTH_IDX) begin
                dth_r[g]  <= PWDATA[7:0];
                duty_r[g] <= {PWDATA[7:0], dtl_r[g]};
            end
        end

        assign raw[g] = cnt_r < duty_r[g];
        assign wave[g] = raw[g] ^ ctl_r[g].invert;
    end

    // clock source and prescale
    assign group_en = clk_cfg_r[pgp_pkg::CLK_EN_BIT];
    always_comb begin
        src_tick = 1'b1;
        if (clk_cfg_r[pgp_pkg::CLK_SRC_BIT]) begin
            src_tick = src_gate_r[pgp_pkg::SRC_DOUBLE_BIT] ? FAST_OSC_X2_TICK
                                                          : FAST_OSC_TICK;
        end
    end
    assign pre_mask = 7'((8'h01 << clk_cfg_r[pgp_pkg::CLK_PRE_LSB +: 3]) - 8'h01);
    assign pre_tick = src_tick && ((pre_r & pre_mask) == pre_mask);
    // bound bit 0 is not held by any register and counts as zero
    assign bound    = {ub_high_r, ub_low_r, 1'b0};

    always_ff @(posedge SYS_CLK or negedge NRST) begin
        if (!NRST) begin
            pre_r <= pgp_pkg::RST_PRE;
        end else if (!group_en) begin
            pre_r <= pgp_pkg::RST_PRE;
        end else if (src_tick) begin
            pre_r <= (pre_r & pre_mask) == pre_mask ? pgp_pkg::RST_PRE : pre_r + 7'h01;
        end
    end

    always_ff @(posedge SYS_CLK or negedge NRST) begin
        if (!NRST) begin
            cnt_r <= pgp_pkg::RST_CNT;
        end else if (!group_en) begin
            cnt_r <= pgp_pkg::RST_CNT;
        end else if (pre_tick) begin
            cnt_r <= (cnt_r >= bound) ? pgp_pkg::RST_CNT : cnt_r + 11'h001;
        end
    end

    // gen2 half rate: toggles on each rising edge of its wave
    always_ff @(posedge SYS_CLK or negedge NRST) begin
        if (!NRST) begin
            half_r    <= 1'b0;
            w2_prev_r <= 1'b0;
        end else if (!group_en) begin
            half_r    <= 1'b0;
            w2_prev_r <= 1'b0;
        end else begin
            w2_prev_r <= wave[2];
            if (wave[2] && !w2_prev_r) begin
                half_r <= !half_r;
            end
        end
    end

    // output selection and comparator gating
    always_comb begin
        sel_out[0] = wave[0];
        if (ctl_r[0].sel) begin
            sel_out[0] = ctl_r[0].mix_or ? (wave[0] | wave[1]) : (wave[0] ^ wave[1]);
        end
        sel_out[1] = ctl_r[1].sel ? wave[2] : wave[1];
        sel_out[2] = ctl_r[2].sel ? half_r : wave[2];
        for (int i = 0; i < 3; i++) begin
            if (src_gate_r[pgp_pkg::GATE_LSB + i] && !CMP_RESULT) begin
                sel_out[i] = 1'b0;
            end
        end
    end

    always_ff @(posedge SYS_CLK or negedge NRST) begin
        if (!NRST) begin
            gen_out_r <= 3'h0;
        end else begin
            gen_out_r <= group_en ? sel_out : 3'h0;
        end
    end

    // pin routing
    always_ff @(posedge SYS_CLK or negedge NRST) begin
        if (!NRST) begin
            pin0_r <= '0;
            pin3_r <= '0;
            pin4_r <= '0;
            pin7_r <= '0;
        end else begin
            pin3_r.oe  <= ctl_r[0].route[1];
            pin3_r.out <= ctl_r[0].route[1] && gen_out_r[0];
            pin4_r.oe  <= ctl_r[1].route[1];
            pin4_r.out <= ctl_r[1].route[1] && gen_out_r[1];
            pin0_r.oe  <= ctl_r[2].route == pgp_pkg::ROUTE_BIT0;
            pin0_r.out <= ctl_r[2].route == pgp_pkg::ROUTE_BIT0 && gen_out_r[2];
            pin7_r.oe  <= ctl_r[2].route == pgp_pkg::ROUTE_BIT7;
            pin7_r.out <= ctl_r[2].route == pgp_pkg::ROUTE_BIT7 && gen_out_r[2];
        end
    end

    assign PORT_A_BIT0_OUT = pin0_r.out;
    assign PORT_A_BIT0_OE  = pin0_r.oe;
    assign PORT_A_BIT3_OUT = pin3_r.out;
    assign PORT_A_BIT3_OE  = pin3_r.oe;
    assign PORT_A_BIT4_OUT = pin4_r.out;
    assign PORT_A_BIT4_OE  = pin4_r.oe;
    assign PORT_A_BIT7_OUT = pin7_r.out;
    assign PORT_A_BIT7_OE  = pin7_r.oe;

endmodule

// [test/pgp_top_monitor.sv]
// checker for the pwm group: apb handshake and pin enables
// assumes it is bound onto pgp_top, one clock domain
`timescale 1ns/1ps
module pgp_top_monitor (
    // clock and reset
    input wire logic        SYS_CLK,
    input wire logic        NRST,
    // apb
    input wire logic        PSEL,
    input wire logic        PENABLE,
    input wire logic        PWRITE,
    input wire logic [7:0]  PADDR,
    input wire logic [31:0] PRDATA,
    input wire logic        PREADY,
    input wire logic        PSLVERR,
    // pin enables
    input wire logic        PORT_A_BIT0_OE,
    input wire logic        PORT_A_BIT3_OE,
    input wire logic        PORT_A_BIT4_OE,
    input wire logic        PORT_A_BIT7_OE
);
    default clocking cb @(posedge SYS_CLK); endclocking
    default disable iff (!NRST);
    logic wr_done;
    logic unmapped;
    assign wr_done  = PSEL && PENABLE && PREADY && PWRITE;
    assign unmapped = (PADDR[7:2] < 6'h33) || (PADDR[7:2] > 6'h3F);
    property p_one_wait; $rose(PENABLE) && PSEL |=> PREADY; endproperty
    a_one_wait: assert property (p_one_wait) else $error("ready not after one wait");
    property p_ready_pulse; PREADY |=> !PREADY; endproperty
    a_ready_pulse: assert property (p_ready_pulse) else $error("ready held too long");
    property p_ready_access; PREADY |-> PSEL && PENABLE; endproperty
    a_ready_access: assert property (p_ready_access) else $error("ready outside access");
    property p_unmapped; PREADY && unmapped |-> PSLVERR && PRDATA == 32'h0; endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped access not refused");
    property p_mapped; PREADY && !unmapped |-> !PSLVERR && PRDATA[31:8] == 24'h0; endproperty
    a_mapped: assert property (p_mapped) else $error("mapped access refused");
    property p_reset_pins;
        $rose(NRST) |-> !(PORT_A_BIT0_OE || PORT_A_BIT3_OE || PORT_A_BIT4_OE || PORT_A_BIT7_OE);
    endproperty
    a_reset_pins: assert property (p_reset_pins) else $error("pin driven after reset");
    property p_pin3_oe;
        $changed(PORT_A_BIT3_OE) |-> $past(wr_done) || $past(wr_done, 2) || $past(wr_done, 3);
    endproperty
    a_pin3_oe: assert property (p_pin3_oe) else $error("pin3 enable moved without write");
    property p_pin4_oe;
        $changed(PORT_A_BIT4_OE) |-> $past(wr_done) || $past(wr_done, 2) || $past(wr_done, 3);
    endproperty
    a_pin4_oe: assert property (p_pin4_oe) else $error("pin4 enable moved without write");
    property p_pin0_oe;
        $changed(PORT_A_BIT0_OE) |-> $past(wr_done) || $past(wr_done, 2) || $past(wr_done, 3);
    endproperty
    a_pin0_oe: assert property (p_pin0_oe) else $error("pin0 enable moved without write");
    property p_one_route; !(PORT_A_BIT0_OE && PORT_A_BIT7_OE); endproperty
    a_one_route: assert property (p_one_route) else $error("gen2 on two pins");
endmodule
bind pgp_top pgp_top_monitor u_pgp_top_monitor (
    .SYS_CLK(SYS_CLK), .NRST(NRST), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE),
    .PADDR(PADDR), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
    .PORT_A_BIT0_OE(PORT_A_BIT0_OE), .PORT_A_BIT3_OE(PORT_A_BIT3_OE),
    .PORT_A_BIT4_OE(PORT_A_BIT4_OE), .PORT_A_BIT7_OE(PORT_A_BIT7_OE));

// [test/pgp_top_tb.sv]
// self-checking bench for the pwm group: registers over apb, pin waveforms
// assumes pgp_top with its checker bound; oscillator ticks made here
`timescale 1ns/1ps
module pgp_top_tb;
    logic        SYS_CLK = 1'b0;
    logic        NRST = 1'b0;
    logic        PSEL = 1'b0;
    logic        PENABLE = 1'b0;
    logic        PWRITE = 1'b0;
    logic [7:0]  PADDR = 8'h00;
    logic [31:0] PWDATA = 32'h0;
    logic [31:0] PRDATA;
    logic        PREADY, PSLVERR;
    logic        FAST_OSC_TICK = 1'b0;
    logic        FAST_OSC_X2_TICK = 1'b0;
    logic        CMP_RESULT = 1'b0;
    logic        P0_OUT, P0_OE, P3_OUT, P3_OE, P4_OUT, P4_OE, P7_OUT, P7_OE;
    logic [1:0]  tcnt = 2'h0;
    int          msel = 0;
    logic        mpin;
    logic [32:0] exp_q [$];
    int          num_errors = 0;
    int          cmp_count = 0;
    logic [5:0]  ridx [6] = '{6'h34, 6'h35, 6'h36, 6'h37, 6'h38, 6'h39};
    logic [7:0]  msk [6] = '{8'h39, 8'h38, 8'h3C, 8'h71, 8'hFF, 8'hC0};
    int          codes [3] = '{0, 1, 7};

    pgp_top u_pgp_top (
        .SYS_CLK(SYS_CLK), .NRST(NRST), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE),
        .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
        .FAST_OSC_TICK(FAST_OSC_TICK), .FAST_OSC_X2_TICK(FAST_OSC_X2_TICK),
        .CMP_RESULT(CMP_RESULT), .PORT_A_BIT0_OUT(P0_OUT), .PORT_A_BIT0_OE(P0_OE),
        .PORT_A_BIT3_OUT(P3_OUT), .PORT_A_BIT3_OE(P3_OE), .PORT_A_BIT4_OUT(P4_OUT),
        .PORT_A_BIT4_OE(P4_OE), .PORT_A_BIT7_OUT(P7_OUT), .PORT_A_BIT7_OE(P7_OE));

    always #4 SYS_CLK = ~SYS_CLK;
    // pin under measurement: 0 bit3, 1 bit4, 2 bit0, 3 bit7
    assign mpin = (msel == 0) ? P3_OUT : (msel == 1) ? P4_OUT : (msel == 2) ? P0_OUT : P7_OUT;
    // oscillator stand-ins: 16 MHz tick every 4 cycles, doubled rate every 2
    always @(posedge SYS_CLK) begin
        tcnt <= tcnt + 2'h1;
        FAST_OSC_TICK <= (tcnt == 2'h3);
        FAST_OSC_X2_TICK <= tcnt[0];
    end

    task automatic chk(input string nm, input logic [32:0] seen, input logic [32:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            num_errors++;
            $display("FAIL %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic wrap_up;
        $display("comparisons %0d mismatches %0d", cmp_count, num_errors);
        if (num_errors == 0 && cmp_count > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    // reads leave {slverr, data} in the note queue for the watcher
    task automatic apb(input logic w, input logic [5:0] idx, input logic [7:0] d,
                       input logic [32:0] exp);
        int n;
        @(posedge SYS_CLK);
        PSEL <= 1'b1;
        PWRITE <= w;
        PADDR <= {idx, 2'b00};
        PWDATA <= {24'h0, d};
        if (!w)
            exp_q.push_back(exp);
        @(posedge SYS_CLK);
        PENABLE <= 1'b1;
        for (n = 0; n < 16 && PREADY !== 1'b1; n++)
            @(posedge SYS_CLK);
        PSEL <= 1'b0;
        PENABLE <= 1'b0;
        if (n == 16) begin
            num_errors++;
            wrap_up();
        end
    endtask

    always @(posedge SYS_CLK) begin
        if (PSEL && PENABLE && PREADY === 1'b1 && !PWRITE) begin
            if (exp_q.size() == 0)
                chk("read_without_note", 33'h1, 33'h0);
            else
                chk("read_data", {PSLVERR, PRDATA}, exp_q.pop_front());
        end
    end

    // settle n+8 cycles, then count high cycles and rising edges on the chosen pin over n
    task automatic meas(input int n, input int exp_hi, input int exp_rise);
        int   hi;
        int   rise;
        logic prev;
        hi = 0;
        rise = 0;
        repeat (n + 8) @(posedge SYS_CLK);
        prev = mpin;
        repeat (n) begin
            @(posedge SYS_CLK);
            hi += int'(mpin === 1'b1);
            rise += int'(mpin === 1'b1 && prev === 1'b0);
            prev = mpin;
        end
        chk("pin_high", 33'(hi), 33'(exp_hi));
        chk("pin_rise", 33'(rise), 33'(exp_rise));
    endtask

    initial begin
        logic [7:0] d;
        void'($urandom(32'h2c320c54));
        repeat (20) @(posedge SYS_CLK);
        NRST <= 1'b1;
        for (int i = 8'h33; i <= 8'h3F; i++)
            apb(1'b0, 6'(i), 8'h00, 33'h0);
        apb(1'b0, 6'h10, 8'h00, {1'b1, 32'h0});
        apb(1'b1, 6'h10, 8'hFF, 33'h0);
        $display("test reset_and_unmapped done");
        for (int i = 0; i < 6; i++) begin
            d = 8'($urandom()) & msk[i];
            apb(1'b1, ridx[i], d, 33'h0);
            apb(1'b0, ridx[i], 8'h00, {25'h0, d});
        end
        $display("test register_access done");
        // bound 8 gives a 9-count period; duty 3 is high for 3 counts
        apb(1'b1, pgp_pkg::IDX_UB_HIGH, 8'h01, 33'h0);
        apb(1'b1, pgp_pkg::IDX_UB_LOW, 8'h00, 33'h0);
        apb(1'b1, pgp_pkg::IDX_DUTY_L0, 8'h60, 33'h0);
        apb(1'b1, pgp_pkg::IDX_DUTY_H0, 8'h00, 33'h0);
        apb(1'b1, pgp_pkg::IDX_SRC_GATE, 8'h00, 33'h0);
        apb(1'b1, pgp_pkg::IDX_GEN0_CTL, 8'h08, 33'h0);
        for (int i = 0; i < 3; i++) begin
            apb(1'b1, pgp_pkg::IDX_CLK_CFG, 8'h80 | 8'(codes[i] << 4), 33'h0);
            meas(36 << codes[i], 12 << codes[i], 4);
        end
        chk("pin3_oe", {32'h0, P3_OE}, 33'h1);
        // back to divide by one before the short windows below
        apb(1'b1, pgp_pkg::IDX_CLK_CFG, 8'h80, 33'h0);
        apb(1'b1, pgp_pkg::IDX_GEN0_CTL, 8'h28, 33'h0);
        meas(36, 24, 4);
        apb(1'b1, pgp_pkg::IDX_DUTY_L0, 8'h00, 33'h0);
        apb(1'b1, pgp_pkg::IDX_DUTY_H0, 8'h00, 33'h0);
        repeat (8) @(posedge SYS_CLK);
        apb(1'b0, pgp_pkg::IDX_GEN0_CTL, 8'h00, {25'h0, 8'h68});
        apb(1'b1, pgp_pkg::IDX_SRC_GATE, 8'h01, 33'h0);
        meas(36, 0, 0);
        CMP_RESULT <= 1'b1;
        meas(36, 36, 0);
        apb(1'b1, pgp_pkg::IDX_DUTY_L0, 8'h60, 33'h0);
        apb(1'b1, pgp_pkg::IDX_DUTY_H0, 8'h00, 33'h0);
        apb(1'b1, 6'h3D, 8'h00, 33'h0);
        apb(1'b1, 6'h3C, 8'h01, 33'h0);
        // gen1 polarity was left random by the register test
        apb(1'b1, pgp_pkg::IDX_GEN1_CTL, 8'h00, 33'h0);
        apb(1'b1, pgp_pkg::IDX_SRC_GATE, 8'h00, 33'h0);
        apb(1'b1, pgp_pkg::IDX_GEN0_CTL, 8'h18, 33'h0);
        meas(36, 20, 4);
        apb(1'b1, pgp_pkg::IDX_GEN0_CTL, 8'h19, 33'h0);
        meas(36, 32, 4);
        $display("test waveforms done");
        apb(1'b1, pgp_pkg::IDX_GEN0_CTL, 8'h08, 33'h0);
        apb(1'b1, pgp_pkg::IDX_CLK_CFG, 8'h81, 33'h0);
        meas(144, 48, 4);
        apb(1'b1, pgp_pkg::IDX_SRC_GATE, 8'h08, 33'h0);
        meas(144, 48, 8);
        for (int r = 0; r < 4; r++) begin
            apb(1'b1, pgp_pkg::IDX_GEN2_CTL, {4'h0, 2'(r), 2'b00}, 33'h0);
            repeat (4) @(posedge SYS_CLK);
            chk("pin0_oe", {32'h0, P0_OE}, {32'h0, r == 1});
            chk("pin7_oe", {32'h0, P7_OE}, {32'h0, r == 2});
        end
        apb(1'b1, pgp_pkg::IDX_GEN1_CTL, 8'h08, 33'h0);
        repeat (4) @(posedge SYS_CLK);
        chk("pin4_oe", {32'h0, P4_OE}, 33'h1);
        $display("test clock_and_routes done");
        // gen2 duty 3, gen1 duty 8, bound 8, system clock
        apb(1'b1, pgp_pkg::IDX_CLK_CFG, 8'h80, 33'h0);
        apb(1'b1, 6'h3F, 8'h60, 33'h0);
        apb(1'b1, 6'h3E, 8'h00, 33'h0);
        msel <= 1;
        meas(36, 32, 4);
        apb(1'b1, pgp_pkg::IDX_GEN1_CTL, 8'h18, 33'h0);
        meas(36, 12, 4);
        apb(1'b1, pgp_pkg::IDX_GEN2_CTL, 8'h04, 33'h0);
        msel <= 2;
        meas(36, 12, 4);
        apb(1'b1, pgp_pkg::IDX_GEN2_CTL, 8'h14, 33'h0);
        meas(36, 18, 2);
        apb(1'b1, pgp_pkg::IDX_GEN2_CTL, 8'h08, 33'h0);
        msel <= 3;
        meas(36, 12, 4);
        $display("test select_and_half_rate done");
        wrap_up();
    end

    initial begin
        repeat (90000) @(posedge SYS_CLK);
        num_errors++;
        wrap_up();
    end
endmodule
